// ===== rtl/ppi_top.sv
/*
  ppi_top: port pin interrupt front end: port 2 pending flags, the port
  interrupt control register, per-port edge events and one irq line.
  assumes: pins are asynchronous to clk; register port master as usual.
*/
`timescale 1ns/1ps
module ppi_top (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [7:0] rdata,
  input wire logic [7:0] port0_pin,
  input wire logic [7:0] port1_pin,
  input wire logic [4:0] port2_pin,
  input wire logic usb_resume,
  input wire logic usb_variant,
  output logic port0_irq_req,
  output logic port1_irq_req,
  output logic port2_irq_req,
  output logic irq
);
  import ppi_pkg::*;

  // ****************************************************
  // pin synchronisers
  // ****************************************************
  logic [20:0] raw_in;
  logic [20:0] sync1_reg;
  logic [20:0] sync2_reg;
  logic [7:0] p0_eff;
  logic [7:0] edge_ctrl_reg;
  logic [4:0] p2_pend_reg;
  logic [7:0] stat_reg;
  logic [7:0] mask_reg;
  logic [7:0] p0_evt_reg;
  logic [7:0] p1_evt_reg;

  // usb resume replaces pin 7 of port 0 on the usb variant
  always_comb begin
    p0_eff = port0_pin;
    if (usb_variant) begin
      p0_eff[BIT_USB_IN] = usb_resume;
    end
  end

  assign raw_in = {port2_pin, port1_pin, p0_eff};

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sync1_reg <= 21'h000000;
      sync2_reg <= 21'h000000;
    end else begin
      sync1_reg <= raw_in;
      sync2_reg <= sync1_reg;
    end
  end

  // ****************************************************
  // edge detection
  // ****************************************************
  ppi_edge_if eif ();
  logic [7:0] p0_hit;
  logic [7:0] p1_hit;
  logic [4:0] p2_hit;

  assign eif.level = sync2_reg;
  // one polarity bit fans out to a whole port
  assign eif.falling_sel = {{5{edge_ctrl_reg[BIT_P2_EDGE]}},
                            {8{edge_ctrl_reg[BIT_P1_EDGE]}},
                            {8{edge_ctrl_reg[BIT_P0_EDGE]}}};
  assign p0_hit = eif.edge_hit[7:0];
  assign p1_hit = eif.edge_hit[15:8];
  assign p2_hit = eif.edge_hit[20:16];

  ppi_edge_det u_det (
    .clk(clk),
    .sys_rst(sys_rst),
    .e(eif)
  );

  // ****************************************************
  // register writes
  // ****************************************************
  logic wr_edge_ctrl;
  logic wr_p2;
  logic wr_stat;
  logic wr_mask;
  logic [4:0] p2_pend_next;
  logic [7:0] stat_next;
  logic [7:0] evt_now;

  assign wr_edge_ctrl = wr_stb && (addr == ADDR_EDGE_CTRL);
  assign wr_p2 = wr_stb && (addr == ADDR_P2_PEND);
  assign wr_stat = wr_stb && (addr == ADDR_IRQ_STAT);
  assign wr_mask = wr_stb && (addr == ADDR_IRQ_MASK);

  // bit 7 is read-only zero; bit 6 stores but does nothing
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      edge_ctrl_reg <= EDGE_CTRL_RST;
    end else if (wr_edge_ctrl) begin
      edge_ctrl_reg <= wdata & EDGE_CTRL_WMASK;
    end
  end

  // set beats clear so an edge in the clearing cycle survives
  always_comb begin
    p2_pend_next = p2_pend_reg;
    if (wr_p2) begin
      p2_pend_next = p2_pend_reg & wdata[P2_PINS-1:0];
    end
    p2_pend_next = p2_pend_next | p2_hit;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      p2_pend_reg <= P2_PEND_RST;
    end else begin
      p2_pend_reg <= p2_pend_next;
    end
  end

  // port 0 and port 1 edge events, registered for one cycle only for the outer flag logic
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      p0_evt_reg <= 8'h00;
      p1_evt_reg <= 8'h00;
    end else begin
      p0_evt_reg <= p0_hit;
      p1_evt_reg <= p1_hit;
    end
  end

  // ****************************************************
  // request gating
  // ****************************************************
  logic p0_req;
  logic p1_req;
  logic p2_req;

  assign p0_req = (edge_ctrl_reg[BIT_P0_HI_GATE] && (|p0_evt_reg[7:4]))
               || (edge_ctrl_reg[BIT_P0_LO_GATE] && (|p0_evt_reg[3:0]));
  // port 1 gate lives in its own mask elsewhere
  assign p1_req = |p1_evt_reg;
  assign p2_req = edge_ctrl_reg[BIT_P2_GATE] && (|p2_pend_reg);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      port0_irq_req <= 1'b0;
      port1_irq_req <= 1'b0;
      port2_irq_req <= 1'b0;
    end else begin
      port0_irq_req <= p0_req;
      port1_irq_req <= p1_req;
      port2_irq_req <= p2_req;
    end
  end

  // ****************************************************
  // interrupt status and mask
  // ****************************************************
  always_comb begin
    evt_now = 8'h00;
    evt_now[IRQ_P0] = p0_req;
    evt_now[IRQ_P1] = p1_req;
    evt_now[IRQ_P2] = |p2_hit;
    stat_next = stat_reg;
    if (wr_stat) begin
      stat_next = stat_reg & ~wdata;
    end
    stat_next = (stat_next | evt_now) & IRQ_WMASK;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      stat_reg <= IRQ_RST;
    end else begin
      stat_reg <= stat_next;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mask_reg <= IRQ_RST;
    end else if (wr_mask) begin
      mask_reg <= wdata & IRQ_WMASK;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq <= 1'b0;
    end else begin
      // new mask taken at once so irq follows it without a lag
      irq <= |(stat_next & (wr_mask ? (wdata & IRQ_WMASK) : mask_reg));
    end
  end

  // ****************************************************
  // register reads
  // ****************************************************
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata <= 8'h00;
    end else if (rd_stb) begin
      case (addr)
        ADDR_P2_PEND: rdata <= {3'h0, p2_pend_reg};
        ADDR_EDGE_CTRL: rdata <= edge_ctrl_reg;
        ADDR_IRQ_STAT: rdata <= stat_reg;
        ADDR_IRQ_MASK: rdata <= mask_reg;
        ADDR_P0_STAT: rdata <= sync2_reg[7:0];
        ADDR_P1_STAT: rdata <= sync2_reg[15:8];
        default: rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end

  // ****************************************************
  // checks
  // ****************************************************
  property p_pend_set;
    @(posedge clk) disable iff (sys_rst)
      (|p2_hit) |=> ((p2_pend_reg & $past(p2_hit)) == $past(p2_hit));
  endproperty
  a_pend_set: assert property (p_pend_set)
    else $error("port 2 edge did not set pending flag");

  property p_clear_zero;
    @(posedge clk) disable iff (sys_rst)
      (wr_p2 && !(|p2_hit)) |=>
        (p2_pend_reg == ($past(p2_pend_reg) & $past(wdata[4:0])));
  endproperty
  a_clear_zero: assert property (p_clear_zero)
    else $error("pending flag write not zero-clear");

  property p_p2_read;
    @(posedge clk) disable iff (sys_rst)
      (rd_stb && addr == ADDR_P2_PEND) |=> (rdata[7:5] == 3'h0);
  endproperty
  a_p2_read: assert property (p_p2_read)
    else $error("unused port 2 flag bits read nonzero");

  property p_p2_gate;
    @(posedge clk) disable iff (sys_rst)
      !edge_ctrl_reg[BIT_P2_GATE] |=> !port2_irq_req;
  endproperty
  a_p2_gate: assert property (p_p2_gate)
    else $error("port 2 request while gated");

  property p_p0_hi;
    @(posedge clk) disable iff (sys_rst)
      (edge_ctrl_reg[BIT_P0_HI_GATE] && |p0_evt_reg[7:4]) |=> port0_irq_req;
  endproperty
  a_p0_hi: assert property (p_p0_hi)
    else $error("upper port 0 event not passed");

  property p_p0_lo;
    @(posedge clk) disable iff (sys_rst)
      (!edge_ctrl_reg[BIT_P0_LO_GATE] && !edge_ctrl_reg[BIT_P0_HI_GATE])
        |=> !port0_irq_req;
  endproperty
  a_p0_lo: assert property (p_p0_lo)
    else $error("port 0 request while both gates off");

  property p_rise;
    @(posedge clk) disable iff (sys_rst)
      (!edge_ctrl_reg[BIT_P2_EDGE] && !$past(sync2_reg[16]) && sync2_reg[16])
        |-> p2_hit[0];
  endproperty
  a_rise: assert property (p_rise)
    else $error("rising edge missed on port 2");

  property p_usb;
    @(posedge clk) disable iff (sys_rst)
      (usb_variant && usb_resume) |=> ##1 sync2_reg[BIT_USB_IN];
  endproperty
  a_usb: assert property (p_usb)
    else $error("usb resume not routed to port 0 input 7");

  property p_p1_fall;
    @(posedge clk) disable iff (sys_rst)
      (edge_ctrl_reg[BIT_P1_EDGE] && $past(sync2_reg[8]) && !sync2_reg[8])
        |-> p1_hit[0];
  endproperty
  a_p1_fall: assert property (p_p1_fall)
    else $error("falling edge missed on port 1");

  property p_p0_fall;
    @(posedge clk) disable iff (sys_rst)
      (edge_ctrl_reg[BIT_P0_EDGE] && !$past(sync2_reg[0]) && sync2_reg[0])
        |-> !p0_hit[0];
  endproperty
  a_p0_fall: assert property (p_p0_fall)
    else $error("rising edge taken in falling mode");
endmodule // ppi_top

// ===== include/ppi_pkg.sv
/*
  ppi_pkg: register map, field positions, reset values and interrupt
  register layout for the port pin interrupt front end.
  assumes: single clock domain, byte-wide register port.
*/
package ppi_pkg;
  // ****************************************************
  // register offsets
  // ****************************************************
  localparam logic [7:0] ADDR_P2_PEND = 8'h8b;
  localparam logic [7:0] ADDR_EDGE_CTRL = 8'h8c;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'hc0;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'hc1;
  localparam logic [7:0] ADDR_P0_STAT = 8'hc2;
  localparam logic [7:0] ADDR_P1_STAT = 8'hc3;
  // ****************************************************
  // fields
  // ****************************************************
  localparam int P2_PINS = 5;
  localparam int BIT_P2_GATE = 5;
  localparam int BIT_P0_HI_GATE = 4;
  localparam int BIT_P0_LO_GATE = 3;
  localparam int BIT_P2_EDGE = 2;
  localparam int BIT_P1_EDGE = 1;
  localparam int BIT_P0_EDGE = 0;
  localparam int BIT_USB_IN = 7;
  localparam logic [7:0] EDGE_CTRL_WMASK = 8'h7f;
  localparam logic [7:0] EDGE_CTRL_RST = 8'h00;
  localparam logic [4:0] P2_PEND_RST = 5'h00;
  localparam logic [7:0] IRQ_RST = 8'h00;
  // interrupt status layout: bit0 port0, bit1 port1, bit2 port2
  localparam int IRQ_P0 = 0;
  localparam int IRQ_P1 = 1;
  localparam int IRQ_P2 = 2;
  localparam logic [7:0] IRQ_WMASK = 8'h07;
endpackage

// ===== include/ppi_edge_if.sv
/*
  ppi_edge_if: carries synchronised pin levels, polarity and the detected
  edge pulses between the top and the edge detector.
  assumes: one clock domain.
*/
`timescale 1ns/1ps
interface ppi_edge_if;
  logic [20:0] level;
  logic [20:0] falling_sel;
  logic [20:0] edge_hit;
  modport top (output level, output falling_sel, input edge_hit);
  modport det (input level, input falling_sel, output edge_hit);
endinterface

// ===== rtl/ppi_edge_det.sv
/*
  ppi_edge_det: per-input edge detector with selectable polarity.
  assumes: inputs already synchronised to clk.
*/
`timescale 1ns/1ps
module ppi_edge_det (
  input wire logic clk,
  input wire logic sys_rst,
  ppi_edge_if.det e
);
  logic [20:0] last_reg;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      last_reg <= 21'h000000;
    end else begin
      last_reg <= e.level;
    end
  end

  genvar i;
  generate
    for (i = 0; i < 21; i++) begin : g_edge
      // rising when select is 0, falling when 1
      assign e.edge_hit[i] = e.falling_sel[i] ?
        (last_reg[i] & ~e.level[i]) : (~last_reg[i] & e.level[i]);
    end
  endgenerate
endmodule // ppi_edge_det

// ===== sim/ppi_pin_model.sv
/*
  ppi_pin_model: far side of the port pins, driving pin levels.
  assumes: pins are sampled through synchronisers inside the block.
*/
`timescale 1ns/1ps
module ppi_pin_model (
  input wire logic clk,
  output logic [7:0] port0_pin,
  output logic [7:0] port1_pin,
  output logic [4:0] port2_pin
);
  initial begin
    port0_pin = 8'h00;
    port1_pin = 8'h00;
    port2_pin = 5'h00;
  end
  // ****************************************************
  // pin changes
  // ****************************************************
  // levels move just after an edge, then hold: no glitches
  task automatic drive(input int port, input int pin, input logic val);
    @(posedge clk);
    case (port)
      0: port0_pin[pin] <= val;
      1: port1_pin[pin] <= val;
      default: port2_pin[pin] <= val;
    endcase
  endtask
endmodule // ppi_pin_model

// ===== sim/tb_ppi_top.sv
/*
  tb_ppi_top: self-checking bench for the port pin interrupt front end.
  assumes: ppi_pkg compiled first; pins driven by ppi_pin_model.
*/
`timescale 1ns/1ps
module tb_ppi_top;
  import ppi_pkg::*;
  logic clk, sys_rst, wr_stb, rd_stb, usb_resume, usb_variant;
  logic [7:0] addr, wdata, rdata, port0_pin, port1_pin;
  logic [4:0] port2_pin;
  logic port0_irq_req, port1_irq_req, port2_irq_req, irq;
  int n_errors = 0;
  int tests_run = 0;
  ppi_top dut (.clk(clk), .sys_rst(sys_rst), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
    .port0_pin(port0_pin), .port1_pin(port1_pin), .port2_pin(port2_pin),
    .usb_resume(usb_resume), .usb_variant(usb_variant),
    .port0_irq_req(port0_irq_req), .port1_irq_req(port1_irq_req),
    .port2_irq_req(port2_irq_req), .irq(irq));
  ppi_pin_model pins (.clk(clk), .port0_pin(port0_pin),
    .port1_pin(port1_pin), .port2_pin(port2_pin));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // ****************************************************
  // shared tasks
  // ****************************************************
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1 check(rdata, exp);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // polarity changes raise no event; let earlier edges settle and clear any flags left set
  task automatic cfg(input logic [7:0] d);
    wr(ADDR_EDGE_CTRL, d);
    cyc(6);
    wr(ADDR_P2_PEND, 8'h00);
    wr(ADDR_IRQ_STAT, 8'h07);
  endtask
  // port 3 stands for the usb resume line; counts request pulses
  task automatic step(input int port, input int pin, input logic val,
      input logic [7:0] exp);
    logic [7:0] c;
    c = 8'h00;
    if (port == 3) begin
      @(posedge clk);
      usb_resume <= val;
    end else begin
      pins.drive(port, pin, val);
    end
    repeat (8) begin
      @(posedge clk);
      #1 if ((port == 1) ? port1_irq_req === 1'b1 : port0_irq_req === 1'b1)
        c = c + 8'h01;
    end
    check(c, exp);
  endtask
  // ****************************************************
  // scenarios
  // ****************************************************
  task automatic t_reset();
    rd_chk(ADDR_P2_PEND, 8'h00);
    rd_chk(ADDR_EDGE_CTRL, 8'h00);
    rd_chk(8'h10, 8'h00);
    wr(ADDR_P2_PEND, 8'hff);
    rd_chk(ADDR_P2_PEND, 8'h00);
    wr(ADDR_EDGE_CTRL, 8'hff);
    rd_chk(ADDR_EDGE_CTRL, 8'h7f);
    cfg(8'h00);
  endtask
  task automatic t_port2();
    wr(ADDR_IRQ_MASK, 8'h04);
    pins.drive(2, 0, 1'b1);
    cyc(6);
    check({7'h00, port2_irq_req}, 8'h00);
    check({7'h00, irq}, 8'h01);
    rd_chk(ADDR_P2_PEND, 8'h01);
    wr(ADDR_P2_PEND, 8'hff);
    rd_chk(ADDR_P2_PEND, 8'h01);
    wr(ADDR_P2_PEND, 8'hfe);
    rd_chk(ADDR_P2_PEND, 8'h00);
    wr(ADDR_IRQ_MASK, 8'h00);
    cyc(2);
    check({7'h00, irq}, 8'h00);
    wr(ADDR_IRQ_STAT, 8'h04);
    wr(ADDR_IRQ_MASK, 8'h04);
    cyc(2);
    check({7'h00, irq}, 8'h00);
    cfg(8'h20);
    pins.drive(2, 3, 1'b1);
    cyc(6);
    check({7'h00, port2_irq_req}, 8'h01);
    rd_chk(ADDR_P2_PEND, 8'h08);
    cfg(8'h24);
    pins.drive(2, 3, 1'b0);
    pins.drive(2, 4, 1'b1);
    cyc(6);
    rd_chk(ADDR_P2_PEND, 8'h08);
    wr(ADDR_P2_PEND, 8'h00);
    cyc(3);
    check({7'h00, port2_irq_req}, 8'h00);
    cfg(8'h00);
  endtask
  task automatic t_port0();
    cfg(8'h08);
    step(0, 1, 1'b1, 8'h01);
    step(0, 5, 1'b1, 8'h00);
    step(0, 1, 1'b0, 8'h00);
    cfg(8'h10);
    step(0, 2, 1'b1, 8'h00);
    step(0, 6, 1'b1, 8'h01);
    cfg(8'h19);
    step(0, 6, 1'b0, 8'h01);
    step(0, 4, 1'b1, 8'h00);
    // usb in use: port 0 edge kept rising
    cfg(8'h10);
    step(3, 0, 1'b1, 8'h01);
    step(0, 7, 1'b1, 8'h00);
    step(3, 0, 1'b0, 8'h00);
    // strap off: pin 7 is a plain input again; the swap is itself an edge
    @(posedge clk);
    usb_variant <= 1'b0;
    cfg(8'h10);
    step(3, 0, 1'b1, 8'h00);
    step(0, 7, 1'b0, 8'h00);
    step(0, 7, 1'b1, 8'h01);
    rd_chk(ADDR_P0_STAT, 8'hb4);
  endtask
  task automatic t_port1();
    cfg(8'h00);
    step(1, 2, 1'b1, 8'h01);
    step(1, 2, 1'b0, 8'h00);
    cfg(8'h02);
    step(1, 3, 1'b1, 8'h00);
    step(1, 3, 1'b0, 8'h01);
  endtask
  // ****************************************************
  // run control
  // ****************************************************
  task automatic results();
    $display("errors %0d comparisons %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // whole run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk);
    n_errors++;
    results();
  end
  initial begin
    sys_rst = 1'b1;
    addr = 8'h00;
    wdata = 8'h00;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    usb_resume = 1'b0;
    usb_variant = 1'b1;
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset();
    t_port2();
    t_port0();
    t_port1();
    results();
  end
endmodule // tb_ppi_top
